// File: design/bldec_core.sv
// Byte load group decoder and operand sequencer with its memory port.
// Assumes memory returns read data combinationally in the cycle mem_rd is high.
// What this block does
// - Every byte copy_instruction between a register and an indexed location takes three bytes, the third being a signed displacement.
// - The displacement is the byte right after the opcode, and any immediate byte follows it.
// - An immediate store to an indexed location is prefix, opcode, displacement, immediate value.
// - The two accumulator loads and stores at a direct address are opcode plus two address bytes.
// - A direct address takes its low half from the first byte after the opcode and its high half from the next.
// - A load of an immediate into a byte register is two bytes, the data byte written to that register.
// - The accumulator loads from index locations by prefixed 7E, from a direct address by 3A and from immediate by 3E.
// - After the first prefix, 77, 70 and 71 store A, B and C at first_index_pointer plus displacement.
// - Opcodes may be a prefix plus a second byte or a single byte, so length is never fixed.
// - Opcode 48 copies register B into C straight after the opcode_fetch_cycle.
// - Opcode 72 stores register D at the byte addressed by main_pointer_pair.
module bldec_core
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [bldec_pkg::BYTE_W-1:0] mem_rdata,
    input wire logic [bldec_pkg::ADDR_W-1:0] first_index_pointer,
    input wire logic [bldec_pkg::ADDR_W-1:0] second_index_pointer,
    input wire logic [2:0] dbg_sel,
    output logic [bldec_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [bldec_pkg::BYTE_W-1:0] mem_wdata,
    output logic [bldec_pkg::ADDR_W-1:0] pc,
    output logic instr_done,
    output logic instr_illegal,
    output logic [bldec_pkg::BYTE_W-1:0] dbg_data
);
    import bldec_pkg::*;

    // ==========================================
    // Reset release.
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==========================================
    // State and register file.
    bldec_state_type state;
    logic [BYTE_W-1:0] opcode;
    logic [BYTE_W-1:0] pfx;
    logic [BYTE_W-1:0] op_b0;
    logic [BYTE_W-1:0] op_b1;
    logic [1:0] opnd_left;
    logic opnd_idx;
    logic rf_we;
    logic [2:0] rf_waddr;
    logic [BYTE_W-1:0] rf_wdata;
    logic [NREG*BYTE_W-1:0] regs_flat;
    logic [BYTE_W-1:0] rv [NREG];

    bldec_regfile bldec_regfile_inst
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .regs_flat(regs_flat)
    );

    for (genvar g = 0; g < NREG; g++)
    begin : g_rv
        assign rv[g] = regs_flat[g*BYTE_W +: BYTE_W];
    end

    // ==========================================
    // Opcode decode.
    wire in_opc = state == ST_OPCODE;
    wire [BYTE_W-1:0] cur_op = in_opc ? mem_rdata : opcode;
    wire [1:0] f_grp = cur_op[GRP_MSB:GRP_LSB];
    wire [2:0] f_dst = cur_op[DST_MSB:DST_LSB];
    wire [2:0] f_src = cur_op[SRC_MSB:SRC_LSB];
    wire pfx_on = pfx != NO_PFX;
    wire is_prefix = in_opc && !pfx_on && (mem_rdata == PFX_FIRST || mem_rdata == PFX_SECOND);
    wire d_move = f_grp == GRP_MOVE && !(f_dst == MEM_CODE && f_src == MEM_CODE);
    wire d_rr = d_move && f_dst != MEM_CODE && f_src != MEM_CODE;
    wire d_ldm = d_move && f_src == MEM_CODE;
    wire d_stm = d_move && f_dst == MEM_CODE;
    wire d_ldi = f_grp == GRP_IMM && f_src == MEM_CODE && f_dst != MEM_CODE;
    wire d_sti = cur_op == OP_ST_IMM;
    wire d_ext = cur_op == OP_LOAD_EXT || cur_op == OP_ST_EXT;
    wire d_ldbc = cur_op == OP_LOAD_BC;
    wire d_ldde = cur_op == OP_LOAD_DE;
    wire d_stbc = cur_op == OP_ST_BC;
    wire d_stde = cur_op == OP_ST_DE;
    wire d_plain = d_move || d_ldi || d_sti || d_ext || d_ldbc || d_ldde || d_stbc || d_stde;
    wire d_legal = pfx_on ? (d_ldm || d_stm || d_sti) : d_plain;
    wire dec_load = d_ldm || cur_op == OP_LOAD_EXT || d_ldbc || d_ldde;
    wire dec_store = d_stm || d_sti || cur_op == OP_ST_EXT || d_stbc || d_stde;
    // indexed forms add a displacement byte
    wire [1:0] n_opnd = {1'b0, pfx_on} + {1'b0, d_ldi || d_sti} + (d_ext ? 2'h2 : 2'h0);

    // ==========================================
    // Operand selection.
    wire [ADDR_W-1:0] idx_ptr = pfx == PFX_SECOND ? second_index_pointer : first_index_pointer;
    // displacement is the first trailing byte
    wire [ADDR_W-1:0] idx_addr = idx_ptr + ADDR_W'($signed(op_b0));
    wire [BYTE_W-1:0] imm_val = pfx_on ? op_b1 : op_b0;
    wire [ADDR_W-1:0] ext_addr = {op_b1, op_b0};
    wire [ADDR_W-1:0] eff_addr = pfx_on ? idx_addr : d_ext ? ext_addr : d_ldbc || d_stbc ? {rv[REG_B], rv[REG_C]}
        : d_ldde || d_stde ? {rv[REG_D], rv[REG_E]} : {rv[REG_H], rv[REG_L]};
    wire [BYTE_W-1:0] store_data = d_sti ? imm_val : d_stm ? rv[f_src] : rv[REG_A];

    // register write: copy right after the opcode fetch, immediate in exec, memory data in load
    assign rf_we = (in_opc && !is_prefix && d_legal && d_rr) || (state == ST_EXEC && d_ldi) || state == ST_LOAD;
    assign rf_waddr = (d_rr || d_ldm || d_ldi) ? f_dst : REG_A;
    assign rf_wdata = state == ST_LOAD ? mem_rdata : state == ST_EXEC ? imm_val : rv[f_src];

    // ==========================================
    // Sequencer.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_FETCH;
            pc <= PC_RESET;
            mem_addr <= '0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= '0;
            opcode <= '0;
            pfx <= NO_PFX;
            op_b0 <= '0;
            op_b1 <= '0;
            opnd_left <= '0;
            opnd_idx <= 1'b0;
            instr_done <= 1'b0;
            instr_illegal <= 1'b0;
            dbg_data <= '0;
        end
        else
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            instr_done <= 1'b0;
            instr_illegal <= 1'b0;
            dbg_data <= rv[dbg_sel];
            unique case (state)
                ST_FETCH:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= pc;
                    pc <= pc + 1'b1;
                    state <= ST_OPCODE;
                end
                ST_OPCODE:
                begin
                    // a prefix fetches a second opcode byte
                    if (is_prefix)
                    begin
                        pfx <= mem_rdata;
                        state <= ST_FETCH;
                    end
                    else if (!d_legal)
                    begin
                        instr_illegal <= 1'b1;
                        pfx <= NO_PFX;
                        state <= ST_FETCH;
                    end
                    else
                    begin
                        opcode <= mem_rdata;
                        opnd_left <= n_opnd;
                        opnd_idx <= 1'b0;
                        state <= n_opnd != 2'h0 ? ST_OPFETCH : d_rr ? ST_DONE : ST_EXEC;
                    end
                end
                ST_OPFETCH:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= pc;
                    pc <= pc + 1'b1;
                    opnd_left <= opnd_left - 1'b1;
                    state <= ST_OPBYTE;
                end
                ST_OPBYTE:
                begin
                    if (!opnd_idx)
                    begin
                        op_b0 <= mem_rdata;
                    end
                    else
                    begin
                        op_b1 <= mem_rdata;
                    end
                    opnd_idx <= 1'b1;
                    state <= opnd_left == 2'h0 ? ST_EXEC : ST_OPFETCH;
                end
                ST_EXEC:
                begin
                    if (dec_load)
                    begin
                        mem_rd <= 1'b1;
                        mem_addr <= eff_addr;
                        state <= ST_LOAD;
                    end
                    else if (dec_store)
                    begin
                        mem_wr <= 1'b1;
                        mem_addr <= eff_addr;
                        mem_wdata <= store_data;
                        state <= ST_DONE;
                    end
                    else
                    begin
                        state <= ST_DONE;
                    end
                end
                ST_LOAD:
                begin
                    state <= ST_DONE;
                end
                ST_DONE:
                begin
                    instr_done <= 1'b1;
                    pfx <= NO_PFX;
                    state <= ST_FETCH;
                end
            endcase
        end
    end

    // ==========================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    index_len_a: assert property ((in_opc && pfx_on && (d_ldm || d_stm)) |=> opnd_left == 2'h1)
        else $error("indexed move not three bytes");
    disp_first_a: assert property ((state == ST_OPBYTE && !opnd_idx && pfx_on) |=> op_b0 == $past(mem_rdata))
        else $error("displacement not first operand");
    idx_imm_len_a: assert property ((in_opc && pfx_on && d_sti) |=> opnd_left == 2'h2 ##1 mem_rd ##2 mem_rd)
        else $error("indexed immediate store not four bytes");
    ext_addr_a: assert property ((mem_wr && opcode == OP_ST_EXT) |-> mem_addr == {op_b1, op_b0})
        else $error("direct address halves swapped");
    imm_reg_a: assert property ((in_opc && !pfx_on && d_ldi) |=> opnd_left == 2'h1 ##2 state == ST_EXEC)
        else $error("immediate load not two bytes");
    acc_idx_a: assert property ((state == ST_EXEC && pfx == PFX_FIRST && opcode == OP_LOAD_A_MEM)
        |=> mem_rd && mem_addr == first_index_pointer + ADDR_W'($signed(op_b0)) ##1 rv[REG_A] == $past(mem_rdata))
        else $error("accumulator indexed load wrong");
    acc_store_a: assert property ((state == ST_EXEC && pfx == PFX_FIRST && opcode == OP_ST_A_MEM)
        |=> mem_wr && mem_wdata == $past(rv[REG_A]))
        else $error("indexed accumulator store wrong");
    prefix_fetch_a: assert property (is_prefix |=> state == ST_FETCH ##1 mem_rd && mem_addr == $past(pc))
        else $error("prefix not followed by opcode fetch");
    copy_bc_a: assert property ((in_opc && !pfx_on && mem_rdata == OP_COPY_B_TO_C) |=> rv[REG_C] == $past(rv[REG_B]))
        else $error("copy B to C failed");
    store_d_a: assert property ((state == ST_EXEC && !pfx_on && opcode == OP_ST_D_MAIN)
        |=> mem_wr && mem_addr == $past({rv[REG_H], rv[REG_L]}) && mem_wdata == $past(rv[REG_D]))
        else $error("store D through main pointer wrong");
    opnd_pc_a: assert property (state == ST_OPFETCH |=> mem_rd && mem_addr == $past(pc) && pc == $past(pc) + 1'b1)
        else $error("operand fetch address wrong");

    idx_imm_c: cover property (state == ST_EXEC && pfx_on && d_sti ##1 mem_wr);
    ext_load_c: cover property (state == ST_LOAD && opcode == OP_LOAD_EXT);
    second_idx_c: cover property (state == ST_LOAD && pfx == PFX_SECOND);
    illegal_c: cover property (instr_illegal);
endmodule : bldec_core

// File: design/bldec_regfile.sv
// Byte register file of eight entries addressed by the opcode register code.
// Assumes one write per cycle from the sequencer.
module bldec_regfile
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [bldec_pkg::BYTE_W-1:0] wdata,
    output logic [bldec_pkg::NREG*bldec_pkg::BYTE_W-1:0] regs_flat
);
    import bldec_pkg::*;

    logic [BYTE_W-1:0] regs [NREG];

    // ==========================================
    // Storage with reset to zero.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs[i] <= '0;
            end
        end
        else if (we)
        begin
            regs[waddr] <= wdata;
        end
    end

    // ==========================================
    // Flat view for the sequencer.
    for (genvar g = 0; g < NREG; g++)
    begin : g_flat
        assign regs_flat[g*BYTE_W +: BYTE_W] = regs[g];
    end
endmodule : bldec_regfile

// File: inc/bldec_pkg.sv
// Constants, encodings and state type for the byte load group decoder.
// Assumes the opcode map of an 8-bit CPU with two index prefixes.
package bldec_pkg;
    // ==========================================
    // Widths and reset values.
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int NREG = 8;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // ==========================================
    // Opcode fields.
    localparam int GRP_MSB = 7;
    localparam int GRP_LSB = 6;
    localparam int DST_MSB = 5;
    localparam int DST_LSB = 3;
    localparam int SRC_MSB = 2;
    localparam int SRC_LSB = 0;
    localparam logic [1:0] GRP_IMM = 2'h0;
    localparam logic [1:0] GRP_MOVE = 2'h1;
    // ==========================================
    // Register codes inside the opcode.
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] MEM_CODE = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;
    // ==========================================
    // Prefixes and fixed opcodes.
    localparam logic [7:0] NO_PFX = 8'h00;
    localparam logic [7:0] PFX_FIRST = 8'hDD;
    localparam logic [7:0] PFX_SECOND = 8'hFD;
    localparam logic [7:0] OP_LOAD_A_MEM = 8'h7E;
    localparam logic [7:0] OP_ST_A_MEM = 8'h77;
    localparam logic [7:0] OP_COPY_B_TO_C = 8'h48;
    localparam logic [7:0] OP_ST_D_MAIN = 8'h72;
    localparam logic [7:0] OP_ST_IMM = 8'h36;
    localparam logic [7:0] OP_LOAD_EXT = 8'h3A;
    localparam logic [7:0] OP_ST_EXT = 8'h32;
    localparam logic [7:0] OP_LOAD_A_IMM = 8'h3E;
    localparam logic [7:0] OP_LOAD_BC = 8'h0A;
    localparam logic [7:0] OP_LOAD_DE = 8'h1A;
    localparam logic [7:0] OP_ST_BC = 8'h02;
    localparam logic [7:0] OP_ST_DE = 8'h12;
    // ==========================================
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_FETCH, ST_OPCODE, ST_OPFETCH, ST_OPBYTE, ST_EXEC, ST_LOAD, ST_DONE
    } bldec_state_type;
endpackage : bldec_pkg

// File: sim/bldec_core_bench.sv
// Self-checking testbench for the byte load group decoder.
// Assumes the memory model is loaded through its load port while reset is held.
module bldec_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import bldec_pkg::*;
    logic sys_clk;
    logic nrst;
    logic [7:0] mem_rdata;
    logic [15:0] idx_first;
    logic [15:0] idx_second;
    logic [15:0] pc;
    logic [2:0] dbg_sel;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic instr_done;
    logic instr_illegal;
    logic [7:0] dbg_data;
    logic fill_we;
    logic [15:0] fill_addr;
    logic [7:0] fill_data;
    logic [31:0] seed;
    logic [31:0] rnd;
    logic [7:0] exp_mem [0:65535];
    logic [7:0] ereg [0:7];
    logic [7:0] prog [$];
    logic [25:0] expq [$];
    logic [15:0] pcv;
    int failures;
    int samples_checked;
    bldec_core bldec_core_inst (.sys_clk(sys_clk), .nrst(nrst), .mem_rdata(mem_rdata),
        .first_index_pointer(idx_first), .second_index_pointer(idx_second), .dbg_sel(dbg_sel),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc(pc),
        .instr_done(instr_done), .instr_illegal(instr_illegal), .dbg_data(dbg_data));
    bldec_mem_model bldec_mem_model_inst (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .fill_we(fill_we), .fill_addr(fill_addr),
        .fill_data(fill_data), .mem_rdata(mem_rdata));
    // ==========================================
    // Helpers that build the expected bus events.
    function automatic logic [25:0] ev(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        return {k, a, d};
    endfunction : ev
    function automatic logic [2:0] fix(input logic [2:0] x);
        return (x == MEM_CODE) ? REG_A : x;
    endfunction : fix
    function automatic logic [7:0] rd(input logic [15:0] a);
        expq.push_back(ev(2'h0, a, 8'h00));
        return exp_mem[a];
    endfunction : rd
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        exp_mem[a] = d;
        expq.push_back(ev(2'h1, a, d));
    endtask : wr
    task automatic put(input logic [7:0] b);
        prog.push_back(b);
        exp_mem[pcv] = b;
        expq.push_back(ev(2'h0, pcv, 8'h00));
        pcv = pcv + 16'h0001;
    endtask : put
    // Appends one instruction of kind k and works out its effects.
    task automatic gen(input int k, input logic [7:0] a, input logic [7:0] b);
        logic [2:0] r;
        logic [15:0] ea;
        r = fix(a[2:0]);
        ea = {1'b1, a[6:0], b};
        case (k)
            0: begin put({GRP_IMM, r, MEM_CODE}); put(b); ereg[r] = b; end
            1: begin put({GRP_MOVE, r, fix(a[5:3])}); ereg[r] = ereg[fix(a[5:3])]; end
            2: begin put(8'h3A); put(ea[7:0]); put(ea[15:8]); ereg[7] = rd(ea); end
            3: begin put(8'h32); put(ea[7:0]); put(ea[15:8]); wr(ea, ereg[7]); end
            4, 5: begin put(k == 4 ? 8'hDD : 8'hFD); put(8'h7E); put(a);
                ereg[7] = rd((k == 4 ? idx_first : idx_second) + {{8{a[7]}}, a}); end
            6: begin r = (a[1:0] == 2'h0) ? 3'h7 : {2'h0, a[1:0] == 2'h2};
                put(8'hDD); put({5'h0E, r}); put(b); wr(idx_first + {{8{b[7]}}, b}, ereg[r]); end
            7: begin put(8'hDD); put(8'h36); put(a); put(b); wr(idx_first + {{8{a[7]}}, a}, b); end
            8: begin if (!ereg[4][7]) gen(0, 8'h04, {1'b1, b[6:0]});
                put(8'h72); wr({ereg[4], ereg[5]}, ereg[2]); end
            9:
            begin
                // Illegal forms: the empty slot, a double prefix, an unknown byte, a prefixed move.
                case (a[1:0])
                    2'h0: put(8'h76);
                    2'h1:
                    begin
                        put(8'hDD);
                        put(8'hDD);
                    end
                    2'h2: put(8'hED);
                    default:
                    begin
                        put(8'hFD);
                        put(8'h48);
                    end
                endcase
            end
            10: begin put(8'h48); ereg[1] = ereg[0]; end
            11:
            begin
                // Accumulator through the B/C or D/E pair, kept in high memory.
                r = {1'b0, a[0], 1'b0};
                if (!ereg[r][7]) gen(0, {5'h00, r}, {1'b1, b[6:0]});
                put({3'h0, a[0], a[1] ? 4'hA : 4'h2});
                ea = {ereg[r], ereg[r + 3'h1]};
                if (a[1]) ereg[7] = rd(ea);
                else wr(ea, ereg[7]);
            end
            12:
            begin
                // Any register loaded from an index location or from the main pointer pair.
                if (a[7])
                begin
                    put(a[6] ? 8'hFD : 8'hDD);
                    put({GRP_MOVE, r, MEM_CODE});
                    put(b);
                    ereg[r] = rd((a[6] ? idx_second : idx_first) + {{8{b[7]}}, b});
                end
                else
                begin
                    if (!ereg[4][7]) gen(0, 8'h04, {1'b1, b[6:0]});
                    put({GRP_MOVE, r, MEM_CODE});
                    ereg[r] = rd({ereg[4], ereg[5]});
                end
            end
            default:
            begin
                // Stores through the second index pointer.
                put(8'hFD);
                if (a[3])
                begin
                    put(8'h36);
                    put(b);
                    put(a);
                    wr(idx_second + {{8{b[7]}}, b}, a);
                end
                else
                begin
                    put({5'h0E, r});
                    put(b);
                    wr(idx_second + {{8{b[7]}}, b}, ereg[r]);
                end
            end
        endcase
        expq.push_back(ev(k == 9 ? 2'h3 : 2'h2, pcv, 8'h00));
    endtask : gen
    // ==========================================
    // Comparison and verdict.
    task automatic check(input string name, input logic [25:0] seen, input logic [25:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, expv, seen);
        end
    endtask : check
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic take(input logic [25:0] e);
        if (expq.size() > 0)
            check("bus_event", e, expq.pop_front());
    endtask : take
    // ==========================================
    // Clock, watchdog and bus monitor.
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report;
    end
    always @(negedge sys_clk)
    begin
        if (mem_rd === 1'b1) take(ev(2'h0, mem_addr, 8'h00));
        if (mem_wr === 1'b1) take(ev(2'h1, mem_addr, mem_wdata));
        if (instr_done === 1'b1) take(ev(2'h2, pc, 8'h00));
        if (instr_illegal === 1'b1) take(ev(2'h3, pc, 8'h00));
    end
    // ==========================================
    // Main sequence.
    initial
    begin
        seed = 32'h050fe1b7;
        failures = 0;
        samples_checked = 0;
        nrst = 1'b0;
        dbg_sel = 3'h0;
        fill_we = 1'b0;
        fill_addr = 16'h0000;
        fill_data = 8'h00;
        pcv = 16'h0000;
        rnd = $random(seed);
        idx_first = {4'h9, rnd[11:0]};
        idx_second = {4'hA, rnd[27:16]};
        for (int i = 0; i < 65536; i++) exp_mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
        for (int i = 0; i < 8; i++) ereg[i] = 8'h00;
        gen(0, 8'h00, 8'h5C); gen(10, 8'h00, 8'h00); gen(0, 8'h07, 8'h99);
        gen(7, 8'h80, 8'h3C); gen(7, 8'h7F, 8'hC3); gen(2, 8'h6F, 8'h32);
        gen(3, 8'h12, 8'h34); gen(4, 8'hFF, 8'h00); gen(5, 8'h01, 8'h00);
        gen(9, 8'h00, 8'h00); gen(6, 8'h00, 8'h05); gen(6, 8'h01, 8'h85);
        gen(6, 8'h02, 8'h10); gen(8, 8'h00, 8'h11); gen(9, 8'h00, 8'h00);
        gen(9, 8'h01, 8'h00); gen(9, 8'h02, 8'h00); gen(9, 8'h03, 8'h00);
        gen(11, 8'h00, 8'h20); gen(11, 8'h01, 8'h40); gen(11, 8'h02, 8'h60); gen(11, 8'h03, 8'h00);
        gen(12, 8'h03, 8'h00); gen(12, 8'hC2, 8'h80); gen(12, 8'h85, 8'h7F);
        gen(13, 8'h0C, 8'h7F); gen(13, 8'h04, 8'h81);
        for (int i = 0; i < 60; i++)
        begin
            rnd = $random(seed);
            gen(int'(rnd[7:0] % 8'd14), rnd[15:8], rnd[23:16]);
        end
        // A tail of illegal bytes keeps the registers still while they are read.
        repeat (40) prog.push_back(8'h76);
        foreach (prog[i])
        begin
            @(posedge sys_clk);
            #2 fill_we = 1'b1;
            fill_addr = i[15:0];
            fill_data = prog[i];
        end
        @(posedge sys_clk);
        #2 fill_we = 1'b0;
        repeat (4) @(posedge sys_clk);
        #2 nrst = 1'b1;
        for (int n = 0; n < 15000 && expq.size() > 0; n++) @(posedge sys_clk);
        check("events_left", 26'(expq.size()), 26'h0);
        for (int r = 0; r < 8; r++)
        begin
            if (r != 6)
            begin
                @(posedge sys_clk);
                #2 dbg_sel = r[2:0];
                repeat (2) @(posedge sys_clk);
                #1 check("register", {18'h0, dbg_data}, {18'h0, ereg[r]});
            end
        end
        final_report;
    end
endmodule : bldec_core_bench

// File: sim/bldec_mem_model.sv
// Program and data memory model facing the byte load group decoder.
// Assumes zero wait states: read data is combinational while mem_rd is high.
module bldec_mem_model
(
    input wire logic sys_clk,
    input wire logic [bldec_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [bldec_pkg::BYTE_W-1:0] mem_wdata,
    input wire logic fill_we,
    input wire logic [bldec_pkg::ADDR_W-1:0] fill_addr,
    input wire logic [bldec_pkg::BYTE_W-1:0] fill_data,
    output logic [bldec_pkg::BYTE_W-1:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import bldec_pkg::*;
    logic [7:0] store [0:65535];
    logic [7:0] last;
    logic [15:0] ai;
    // ==========================================
    // Fill every location with a pattern derived from its address.
    initial
    begin
        last = 8'h00;
        for (int i = 0; i < 65536; i++)
        begin
            ai = i[15:0];
            store[i] = ai[7:0] ^ ai[15:8] ^ 8'hA5;
        end
    end
    // ==========================================
    // Loading, writes and the last value read.
    always @(posedge sys_clk)
    begin
        if (fill_we)
            store[fill_addr] <= fill_data;
        if (mem_wr)
            store[mem_addr] <= mem_wdata;
        if (mem_rd)
            last <= store[mem_addr];
    end
    // Outside a read the bus shows the inverse of the last byte, not a held value.
    assign mem_rdata = mem_rd ? store[mem_addr] : ~last;
endmodule : bldec_mem_model
